// *** dv/epw_dev_model.sv ***
// Purpose: behavioural eeprom seen at the host pins
// Assumes: clk_in only times the internal write
// Notes:   released bus shows the inverse of the last value
`timescale 1ns/1ns
module epw_dev_model (
    input  wire logic        clk_in,
    input  wire logic [14:0] addr_in,
    input  wire logic        ce_n_in,
    input  wire logic        we_n_in,
    input  wire logic        oe_n_in,
    input  wire logic [7:0]  data_in,
    input  wire logic [31:0] busy_cyc_in,
    output logic [7:0]       data_out
);
    logic [7:0]  mem [0:32767];
    logic [14:0] wa;
    logic [7:0]  rv  = 8'h00;
    logic        tog = 1'b0;
    int          cnt = 0;
    wire         busy = cnt != 0;
    wire         wr   = !we_n_in && !ce_n_in;
    wire         rd   = !oe_n_in && !ce_n_in && we_n_in;
    initial foreach (mem[i]) mem[i] = 8'h00;
    always @(posedge wr) wa = addr_in;
    // bytes land at once, but reads toggle bit 6 until the timer ends
    always @(negedge wr) begin
        mem[wa] = data_in;
        cnt = busy_cyc_in;
    end
    always @(posedge clk_in) if (cnt > 0) cnt <= cnt - 1;
    always @(posedge rd) begin
        rv = mem[addr_in];
        if (busy) begin
            tog = ~tog;
            rv[6] = tog;
        end
    end
    assign data_out = rd ? rv : ~rv;
endmodule : epw_dev_model

// *** dv/testbench.sv ***
// Purpose: self-checking bench for the page-write host
// Assumes: internal write scaled down to tens of cycles, host timeout to hundreds
// Notes:   device memory compared with a bench copy after each done wait
`timescale 1ns/1ns
module testbench;
    localparam int WC = 200;
    logic        clk_in = 0, resetn_in = 0, wr_valid_in = 0, wr_last_in = 0;
    logic [14:0] wr_addr_in = '0, maddr, pa;
    logic [7:0]  wr_data_in = '0, dq, dev_q;
    logic        wr_ready_out, busy_out, done_out, timeout_out, ce_n, we_n, oe_n;
    logic        dq_oe, last_to, pwe = 1, poe = 1, pg_set = 0, po_set = 0;
    logic [8:0]  pg;
    int          mismatches = 0, samples_checked = 0, seed = 26, dcnt = 0, bcyc = 60;
    logic [7:0]  exp_mem [int];
    wire  [7:0]  bus = dq_oe ? dq : dev_q;
    epw_host #(.WC_CYC(WC)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out), .wr_addr_in(wr_addr_in),
        .wr_data_in(wr_data_in), .wr_last_in(wr_last_in), .busy_out(busy_out),
        .done_out(done_out), .timeout_out(timeout_out), .mem_addr_out(maddr),
        .mem_ce_n_out(ce_n), .mem_we_n_out(we_n), .mem_oe_n_out(oe_n),
        .mem_data_in(bus), .mem_data_out(dq), .mem_data_oe_out(dq_oe));
    epw_dev_model dev (.clk_in(clk_in), .addr_in(maddr), .ce_n_in(ce_n), .we_n_in(we_n),
        .oe_n_in(oe_n), .data_in(bus), .busy_cyc_in(bcyc), .data_out(dev_q));
    initial forever #10 clk_in = ~clk_in;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk_in) begin
        if (!we_n && !ce_n) check(oe_n, 1'b1);
        if (!oe_n) check(dq_oe, 1'b0);
        if (pwe && !we_n) begin
            if (pg_set) check(maddr[14:6], pg);
            pg = maddr[14:6];
            pg_set = 1;
        end
        if (poe && !oe_n) begin
            if (po_set) check(maddr, pa);
            pa = maddr;
            po_set = 1;
        end
        if (done_out === 1'b1) begin
            dcnt++;
            last_to = timeout_out;
            pg_set = 0;
            po_set = 0;
            if (!timeout_out) check(dev.busy, 1'b0);
        end
        pwe = we_n;
        poe = oe_n;
    end
    task send(input logic [14:0] a, input logic [7:0] d, input logic l);
        int n;
        n = 0;
        wr_valid_in = 1;
        wr_addr_in = a;
        wr_data_in = d;
        wr_last_in = l;
        while (wr_ready_out !== 1'b1 && n < 5000) begin
            @(negedge clk_in);
            n++;
        end
        check(n < 5000, 1);
        @(negedge clk_in);
    endtask : send
    task page(input int p, input int n, input logic l);
        int off;
        logic [14:0] a;
        logic [7:0] d;
        off = {$random(seed)} % (65 - n);
        for (int i = 0; i < n; i++) begin
            a = {p[8:0], 6'(off + i)};
            d = $random(seed);
            exp_mem[a] = d;
            send(a, d, l && i == n - 1);
        end
    endtask : page
    task wait_done(input int t0, input int k, input logic to);
        int n;
        n = 0;
        wr_valid_in = 0;
        while (dcnt < t0 + k && n < 20000) begin
            @(negedge clk_in);
            n++;
        end
        check(dcnt, t0 + k);
        check(last_to, to);
        check(busy_out, 1'b0);
        foreach (exp_mem[a]) check(dev.mem[a], exp_mem[a]);
        exp_mem.delete();
        $display("test done at %0t", $time);
    endtask : wait_done
    task run(input int p, input int n, input logic to);
        int t0;
        t0 = dcnt;
        page(p, n, 1);
        wait_done(t0, 1, to);
    endtask : run
    initial begin
        int t0;
        repeat (2) @(negedge clk_in);
        resetn_in = 1;
        run(3, 1, 0);
        run(5, 64, 0);
        repeat (4) run($random(seed) & 9'h1FF, 1 + {$random(seed)} % 64, 0);
        // device slower than the host limit: only timeout ends the poll
        bcyc = 3 * WC;
        run(7, 8, 1);
        repeat (3 * WC) @(negedge clk_in);
        bcyc = 60;
        t0 = dcnt;
        page(10, 2, 0);
        page(11, 2, 1);
        wait_done(t0, 2, 0);
        end_of_test();
    end
    initial begin
        #(20 * 60000);
        mismatches++;
        end_of_test();
    end
endmodule : testbench

// *** hw/epw_host.sv ***
// Purpose: page write host with toggle-bit end-of-write polling
// Assumes: pins synchronous to clk_in; device drives data when oe and ce low
// Notes:   one byte per user beat; page ends on last_in, page change, full page, byte gap or valid low
`timescale 1ns/1ns
`include "epw_map.svh"
module epw_host #(
    parameter int AW         = 15,
    parameter int PAGE_BYTES = 64,
    parameter bit FAST_PART  = 1'b0,
    parameter int WC_CYC     = FAST_PART ? `EPW_WC_FAST_CYC : `EPW_WC_STD_CYC,
    parameter int BLC_CYC    = `EPW_BLC_CYC
) (
    input  wire logic          clk_in,
    input  wire logic          resetn_in,
    input  wire logic          wr_valid_in,
    output logic               wr_ready_out,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [7:0]    wr_data_in,
    input  wire logic          wr_last_in,
    output logic               busy_out,
    output logic               done_out,
    output logic               timeout_out,
    output logic [AW-1:0]      mem_addr_out,
    output logic               mem_ce_n_out,
    output logic               mem_we_n_out,
    output logic               mem_oe_n_out,
    input  wire logic [7:0]    mem_data_in,
    output logic [7:0]         mem_data_out,
    output logic               mem_data_oe_out
);
    import epw_pkg::*;
    localparam int TW = 20;
    localparam int PW = $clog2(PAGE_BYTES + 1);

    epw_state_t state;
    logic          tmr_load;
    logic [TW-1:0] tmr_value;
    logic          tmr_zero;
    logic [TW-1:0] gap_count;
    logic [TW-1:0] wc_count;
    logic [AW-1:0] page_addr;
    logic [PW-1:0] loaded;
    logic          last_seen;
    logic          prev_bit;
    logic          have_prev;
    logic          accept;
    logic          same_page;

    function automatic logic [TW-1:0] cyc(input int n);
        cyc = TW'(n);
    endfunction : cyc

    assign same_page = (wr_addr_in[AW-1:`EPW_PAGE_LSB] == page_addr[AW-1:`EPW_PAGE_LSB]);
    // only bytes of the open page are taken, so the page lines stay fixed
    assign wr_ready_out = (state == EPW_IDLE) ||
                          (state == EPW_LOAD_HIGH && tmr_zero && same_page && !last_seen
                           && loaded < PW'(PAGE_BYTES));
    assign accept = wr_valid_in && wr_ready_out;

    epw_timer #(.W(TW)) u_timer (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .load_in   (tmr_load),
        .value_in  (tmr_value),
        .zero_out  (tmr_zero)
    );

    always_comb begin
        tmr_load  = 1'b0;
        tmr_value = '0;
        if (accept) begin
            tmr_load  = 1'b1;
            tmr_value = cyc(`EPW_WP_CYC);
        end else if (state == EPW_LOAD_LOW && tmr_zero) begin
            tmr_load  = 1'b1;
            tmr_value = cyc(`EPW_WPH_CYC);
        end else if (state == EPW_POLL_LOW && tmr_zero) begin
            tmr_load  = 1'b1;
            tmr_value = cyc(`EPW_OEHP_CYC);
        end else if (state == EPW_POLL_HIGH && tmr_zero) begin
            tmr_load  = 1'b1;
            tmr_value = cyc(`EPW_ACC_CYC);
        end
    end

    // byte gap watch: page is closed well before the load window lapses
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gap_count <= '0;
        end else if (accept) begin
            gap_count <= '0;
        end else if (state == EPW_LOAD_HIGH) begin
            gap_count <= gap_count + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wc_count <= '0;
        end else if (state == EPW_POLL_LOW || state == EPW_POLL_HIGH) begin
            wc_count <= wc_count + 1'b1;
        end else begin
            wc_count <= '0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= EPW_IDLE;
        end else begin
            unique case (state)
                EPW_IDLE:      if (accept) state <= EPW_LOAD_LOW;
                EPW_LOAD_LOW:  if (tmr_zero) state <= EPW_LOAD_HIGH;
                EPW_LOAD_HIGH: begin
                    if (accept) begin
                        state <= EPW_LOAD_LOW;
                    end else if (tmr_zero && (last_seen || !wr_valid_in || !same_page
                                 || loaded >= PW'(PAGE_BYTES)
                                 || gap_count >= cyc(BLC_CYC / 2))) begin
                        state <= EPW_POLL_HIGH;
                    end
                end
                EPW_POLL_LOW: begin
                    if (tmr_zero) begin
                        state <= EPW_POLL_HIGH;
                    end
                end
                EPW_POLL_HIGH: begin
                    if (tmr_zero) begin
                        state <= EPW_POLL_LOW;
                    end
                    if (wc_count >= cyc(WC_CYC)) begin
                        state <= EPW_DONE;
                    end
                end
                EPW_DONE:      state <= EPW_IDLE;
            endcase
            // two reads in a row with an equal toggle bit mean programming has ended
            if (state == EPW_POLL_LOW && tmr_zero && have_prev
                && prev_bit == mem_data_in[`EPW_TOGGLE_BIT]) begin
                state <= EPW_DONE;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_bit  <= 1'b0;
            have_prev <= 1'b0;
        end else if (state == EPW_POLL_LOW && tmr_zero) begin
            prev_bit  <= mem_data_in[`EPW_TOGGLE_BIT];
            have_prev <= 1'b1;
        end else if (state == EPW_IDLE) begin
            have_prev <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            page_addr    <= '0;
            mem_addr_out <= '0;
            mem_data_out <= '0;
            loaded       <= '0;
            last_seen    <= 1'b0;
        end else if (accept) begin
            page_addr    <= wr_addr_in;
            mem_addr_out <= wr_addr_in;
            mem_data_out <= wr_data_in;
            loaded       <= (state == EPW_IDLE) ? PW'(1) : loaded + 1'b1;
            last_seen    <= wr_last_in;
        end
        // polling reuses the last loaded address unchanged
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_out    <= 1'b0;
            timeout_out <= 1'b0;
        end else begin
            done_out    <= (state != EPW_DONE) && (
                           (state == EPW_POLL_LOW && tmr_zero && have_prev
                            && prev_bit == mem_data_in[`EPW_TOGGLE_BIT])
                           || (state == EPW_POLL_HIGH && wc_count >= cyc(WC_CYC)));
            timeout_out <= (state == EPW_POLL_HIGH && wc_count >= cyc(WC_CYC))
                           && !(state == EPW_POLL_LOW);
        end
    end

    assign mem_ce_n_out    = !(state == EPW_LOAD_LOW || state == EPW_POLL_LOW);
    assign mem_we_n_out    = !(state == EPW_LOAD_LOW);
    // oe stays high during every write pulse
    assign mem_oe_n_out    = !(state == EPW_POLL_LOW);
    assign mem_data_oe_out = (state == EPW_LOAD_LOW || state == EPW_LOAD_HIGH);
    assign busy_out        = (state != EPW_IDLE);

    property p_oe_we_excl;
        @(posedge clk_in) disable iff (!resetn_in)
        !mem_we_n_out |-> mem_oe_n_out;
    endproperty
    a_oe_we_excl: assert property (p_oe_we_excl)
        else $error("oe low during write pulse");
    property p_page_fixed;
        @(posedge clk_in) disable iff (!resetn_in)
        $fell(mem_we_n_out) && state != EPW_IDLE && $past(state) == EPW_LOAD_HIGH
        |-> mem_addr_out[AW-1:`EPW_PAGE_LSB] == $past(page_addr[AW-1:`EPW_PAGE_LSB]);
    endproperty
    a_page_fixed: assert property (p_page_fixed) else $error("page changed in load");
    property p_prot_page;
        @(posedge clk_in) disable iff (!resetn_in)
        accept && state == EPW_LOAD_HIGH |-> same_page;
    endproperty
    a_prot_page: assert property (p_prot_page) else $error("off-page byte taken");
    property p_gap;
        @(posedge clk_in) disable iff (!resetn_in)
        state == EPW_LOAD_HIGH |-> gap_count < cyc(BLC_CYC);
    endproperty
    a_gap: assert property (p_gap) else $error("byte load window lapsed");
    property p_wc_bound;
        @(posedge clk_in) disable iff (!resetn_in)
        state == EPW_POLL_HIGH || state == EPW_POLL_LOW |-> wc_count <= cyc(WC_CYC) + 8'h10;
    endproperty
    a_wc_bound: assert property (p_wc_bound) else $error("poll ran past write time");
    property p_poll_addr;
        @(posedge clk_in) disable iff (!resetn_in)
        state == EPW_POLL_LOW && $past(state) == EPW_POLL_HIGH |-> $stable(mem_addr_out);
    endproperty
    a_poll_addr: assert property (p_poll_addr) else $error("poll address moved");
    property p_read_pulse;
        @(posedge clk_in) disable iff (!resetn_in)
        $fell(mem_oe_n_out) |-> !mem_ce_n_out && !mem_data_oe_out;
    endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("bad status read");
    property p_done_toggle;
        @(posedge clk_in) disable iff (!resetn_in)
        done_out && !timeout_out |-> $past(prev_bit) == $past(mem_data_in[`EPW_TOGGLE_BIT]);
    endproperty
    a_done_toggle: assert property (p_done_toggle)
        else $error("done while toggling");
    // address and data must not move while a byte is being strobed in
    property p_wr_hold;
        @(posedge clk_in) disable iff (!resetn_in)
        !mem_we_n_out && !$past(mem_we_n_out)
        |-> $stable(mem_addr_out) && $stable(mem_data_out);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write lines moved in pulse");
    property p_done_pulse;
        @(posedge clk_in) disable iff (!resetn_in)
        done_out |=> !done_out && !busy_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
    c_load: cover property (@(posedge clk_in) $fell(mem_we_n_out));
    c_done: cover property (@(posedge clk_in) done_out && !timeout_out);
    c_timeout: cover property (@(posedge clk_in) timeout_out);
endmodule : epw_host

// *** hw/epw_map.svh ***
// Purpose: constants for the parallel eeprom page-write and toggle-poll host
// Assumes: 50 MHz clk_in, 20 ns period
// Notes:   times kept in their own unit, cycle counts derived from them
// Behaviour
// - host presents each next byte load within 150 us of previous
// - host holds page address lines fixed on every write strobe fall
// - with protection active, page address also fixed on every strobe fall
// - host keeps output enable high while write strobe and chip select low
// - polling keeps one constant address for the whole sequence
`ifndef EPW_MAP_SVH
`define EPW_MAP_SVH
`define EPW_CLK_NS          20
`define EPW_TWC_STD_MS      10
`define EPW_TWC_FAST_MS     3
`define EPW_BYTE_LOAD_WINDOW_US         150
`define EPW_TWP_NS          100
`define EPW_TWPH_NS         50
`define EPW_TACC_NS         120
`define EPW_TOEHP_NS        150
`define EPW_WC_STD_CYC      ((`EPW_TWC_STD_MS * 1000000) / `EPW_CLK_NS)
`define EPW_WC_FAST_CYC     ((`EPW_TWC_FAST_MS * 1000000) / `EPW_CLK_NS)
`define EPW_BLC_CYC         ((`EPW_BYTE_LOAD_WINDOW_US * 1000) / `EPW_CLK_NS)
`define EPW_WP_CYC          ((`EPW_TWP_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_WPH_CYC         ((`EPW_TWPH_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_ACC_CYC         ((`EPW_TACC_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_OEHP_CYC        ((`EPW_TOEHP_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_TOGGLE_BIT      6
`define EPW_PAGE_LSB        6
`endif

// *** hw/epw_pkg.sv ***
// Purpose: types for the eeprom page-write host
// Assumes: nothing
// Notes:   constants live in epw_map.svh
package epw_pkg;
    typedef enum logic [2:0] {
        EPW_IDLE,
        EPW_LOAD_LOW,
        EPW_LOAD_HIGH,
        EPW_POLL_LOW,
        EPW_POLL_HIGH,
        EPW_DONE
    } epw_state_t;
endpackage : epw_pkg

// *** hw/epw_timer.sv ***
// Purpose: down counter for strobe widths and poll read timing
// Assumes: load has priority over counting
// Notes:   zero_out is combinational from the count
`timescale 1ns/1ns
module epw_timer #(
    parameter int W = 20
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] value_in,
    output logic              zero_out
);
    logic [W-1:0] count;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count <= '0;
        end else if (load_in) begin
            count <= value_in;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end
    assign zero_out = (count == '0);
endmodule : epw_timer
